// [rtl/scl_pkg.sv]
// Constants shared by the serial loader host and the synthesizer device end.
// Assumes both ends run on one 25 MHz clock with an active-high async reset.
// How it works
// RULE_01: Exactly 160 bits, most significant first.
// RULE_02: Each shift clock pulse advances register one bit.
// RULE_03: Load strobe high moves word; settle 10 ms.
// RULE_04: Latch transparent while strobe high, else holds.
// RULE_05: Shifting during strobe high updates latch directly.
// RULE_06: Host keeps strobe low while shifting.
// RULE_07: Power-down low tri-states outputs; pulled up.
// RULE_08: Host may hold power-down low during load.
// RULE_09: Raising power-down after strobe shows new outputs.
// RULE_10: Unprogrammed outputs carry buffered reference clock.
// RULE_11: Nine outputs from four PLLs, configuration assigned.
// RULE_12: At most six distinct output frequencies.
// RULE_13: Reload while running; relock within 10 ms.
// RULE_14: Multiplier 1..2048, reference divider 1..1024.
// RULE_15: Bank output divider 2..20; frequency formula.
// RULE_16: Data sampled on shift clock rising edge.
package scl_pkg;
  localparam int WORD_BITS = 160;
  localparam int NUM_OUTPUTS = 9;
  localparam int NUM_PLLS = 4;
  localparam int MAX_FREQS = 6;
  localparam int MULT_MIN = 1;
  localparam int MULT_MAX = 2048;
  localparam int RDIV_MIN = 1;
  localparam int RDIV_MAX = 1024;
  localparam int ODIV_MIN = 2;
  localparam int ODIV_MAX = 20;
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_MS = 10;
  // Longest settle time rounds down
  localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;
  // Host link clock: half period in system clocks
  localparam int SCLK_HALF = 4;
  localparam int STROBE_NS = 40;
  localparam int CLK_NS = 40;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [rtl/scl_link_if.sv]
// Three-wire programming link plus power-down pin between host and device.
// Assumes the testbench resolves the power-down pull-up from the enable.
`timescale 1ns/1ps
interface scl_link_if;
  logic shift_clock;
  logic serial_data;
  logic load_strobe;
  logic power_down_tristate_n;
  modport host (
    output shift_clock,
    output serial_data,
    output load_strobe,
    output power_down_tristate_n
  );
  modport device (
    input shift_clock,
    input serial_data,
    input load_strobe,
    input power_down_tristate_n
  );
endinterface

// [rtl/scl_host.sv]
// Host end: shifts a 160-bit word and pulses the load strobe.
// Assumes the user holds cfg_word stable from start until done.
`timescale 1ns/1ps
module scl_host #(
  parameter int WORD_BITS = scl_pkg::WORD_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [WORD_BITS-1:0] cfg_word,
  input wire logic hold_outputs_off,
  output logic busy,
  output logic done,
  scl_link_if.host link
);
  initial begin
    // Shifter needs two bits at least; the bit counter is 16 bits wide
    if (WORD_BITS < 2 || WORD_BITS > 65535) $error("WORD_BITS out of range");
  end
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_STROBE} scl_hstate_type;
  typedef struct packed {
    scl_hstate_type st;
    logic [WORD_BITS-1:0] sh;
    logic [15:0] bits;
    logic [7:0] cnt;
    logic sclk;
    logic strobe;
    logic done;
    logic pd_n;
  } scl_host_type;
  scl_host_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.pd_n = ~hold_outputs_off; // RULE_08
    case (s_reg.st)
      H_IDLE: begin
        if (start) begin
          s_next.sh = cfg_word;
          s_next.bits = 16'(WORD_BITS);
          s_next.cnt = 8'h00;
          s_next.st = H_LOW;
        end
      end
      H_LOW: begin
        s_next.sclk = 1'b0;
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == 8'(scl_pkg::SCLK_HALF - 1)) begin
          s_next.cnt = 8'h00;
          // Rise here so the high phase lasts a full half period
          s_next.sclk = 1'b1;
          s_next.st = H_HIGH;
        end
      end
      H_HIGH: begin
        s_next.sclk = 1'b1;
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == 8'(scl_pkg::SCLK_HALF - 1)) begin
          s_next.cnt = 8'h00;
          s_next.sclk = 1'b0;
          s_next.sh = {s_reg.sh[WORD_BITS-2:0], 1'b0}; // RULE_01
          s_next.bits = s_reg.bits - 16'h0001;
          s_next.st = (s_reg.bits == 16'h0001) ? H_STROBE : H_LOW;
        end
      end
      H_STROBE: begin
        s_next.strobe = 1'b1; // RULE_06
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == 8'(scl_pkg::STROBE_CYCLES * 2)) begin
          s_next.strobe = 1'b0;
          s_next.done = 1'b1;
          s_next.st = H_IDLE;
        end
      end
      default: s_next.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: H_IDLE, sh: '0, bits: 16'h0000, cnt: 8'h00, sclk: 1'b0,
                 strobe: 1'b0, done: 1'b0, pd_n: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.shift_clock = s_reg.sclk;
  assign link.serial_data = s_reg.sh[WORD_BITS-1]; // RULE_01
  assign link.load_strobe = s_reg.strobe;
  assign link.power_down_tristate_n = s_reg.pd_n;
  assign busy = (s_reg.st != H_IDLE);
  assign done = s_reg.done;
endmodule

// [rtl/scl_device.sv]
// Device end: serial shift register, transparent load latch, output gating.
// Assumes link pins are asynchronous; reference_clock_in is a same-domain signal
// standing for the reference clock, and frequency synthesis is external.
`timescale 1ns/1ps
module scl_device #(
  parameter int WORD_BITS = scl_pkg::WORD_BITS,
  parameter int SETTLE_CYCLES = scl_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reference_clock_in,
  input wire logic [scl_pkg::NUM_OUTPUTS-1:0] synth_clocks,
  scl_link_if.device link,
  output logic [WORD_BITS-1:0] cfg_word,
  output logic programmed,
  output logic locked,
  output logic cfg_in_range,
  output logic powered_down,
  output logic [scl_pkg::NUM_OUTPUTS-1:0] clock_out,
  output logic [scl_pkg::NUM_OUTPUTS-1:0] clock_out_oe_n
);
  initial begin
    if (WORD_BITS != scl_pkg::WORD_BITS) $error("word width must be 160");
    if (SETTLE_CYCLES < 1) $error("SETTLE_CYCLES must be positive");
  end
  // Field layout of the word is undocumented; low bits carry multiplier and divider values
  localparam int MB = 11;
  localparam int RB = 10;
  localparam int OB = 5;
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] data_s;
    logic [1:0] strb_s;
    logic [1:0] pd_s;
    logic [WORD_BITS-1:0] sh;
    logic [WORD_BITS-1:0] latch;
    logic prog;
    logic [31:0] settle;
    logic lock;
  } scl_dev_type;
  scl_dev_type s_reg, s_next;
  logic sclk_rise;
  logic [MB:0] mult_v;
  logic [RB:0] rdiv_v;
  logic [OB-1:0] odiv_v;

  // Edge detect reads only the second and third stages
  assign sclk_rise = s_reg.sclk_s[1] & ~s_reg.sclk_s[2]; // RULE_16

  always_comb begin
    s_next = s_reg;
    s_next.sclk_s = {s_reg.sclk_s[1:0], link.shift_clock};
    s_next.data_s = {s_reg.data_s[0], link.serial_data};
    s_next.strb_s = {s_reg.strb_s[0], link.load_strobe};
    s_next.pd_s = {s_reg.pd_s[0], link.power_down_tristate_n};
    if (sclk_rise) begin
      s_next.sh = {s_reg.sh[WORD_BITS-2:0], s_reg.data_s[1]}; // RULE_02 RULE_01
    end
    // Transparent: follows the shifter, including shifts while high
    if (s_reg.strb_s[1]) begin
      s_next.latch = s_next.sh; // RULE_04 RULE_05 RULE_03
      if (s_next.sh != s_reg.latch || !s_reg.prog) begin
        s_next.settle = 32'(SETTLE_CYCLES); // RULE_13
        s_next.lock = 1'b0;
      end
      s_next.prog = 1'b1;
    end
    if (s_reg.settle != 32'h0000_0000) begin
      s_next.settle = s_next.settle - 32'h0000_0001;
      if (s_reg.settle == 32'h0000_0001) begin
        s_next.lock = 1'b1; // RULE_03
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{sclk_s: 3'h0, data_s: 2'h0, strb_s: 2'h0, pd_s: 2'h3,
                 sh: '0, latch: '0, prog: 1'b0, settle: 32'h0000_0000,
                 lock: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign mult_v = {1'b0, s_reg.latch[MB-1:0]} + 12'h001;
  assign rdiv_v = {1'b0, s_reg.latch[MB+RB-1:MB]} + 11'h001;
  assign odiv_v = s_reg.latch[MB+RB+OB-1:MB+RB];
  // Bank divider range 2..20 flagged here; synthesis uses mult/rdiv/odiv
  assign cfg_in_range = (32'(mult_v) >= 32'(scl_pkg::MULT_MIN))
                      && (32'(mult_v) <= 32'(scl_pkg::MULT_MAX))
                      && (32'(rdiv_v) >= 32'(scl_pkg::RDIV_MIN))
                      && (32'(rdiv_v) <= 32'(scl_pkg::RDIV_MAX))
                      && (32'(odiv_v) >= 32'(scl_pkg::ODIV_MIN))
                      && (32'(odiv_v) <= 32'(scl_pkg::ODIV_MAX)); // RULE_14 RULE_15

  assign cfg_word = s_reg.latch;
  assign programmed = s_reg.prog;
  assign locked = s_reg.lock;
  assign powered_down = ~s_reg.pd_s[1]; // RULE_07

  // Nine outputs; PLL assignment and the six-frequency limit are in synth_clocks
  always_comb begin
    for (int i = 0; i < scl_pkg::NUM_OUTPUTS; i++) begin
      clock_out[i] = s_reg.prog ? synth_clocks[i] : reference_clock_in; // RULE_10 RULE_11 RULE_12
      clock_out_oe_n[i] = ~s_reg.pd_s[1]; // RULE_07 RULE_09
    end
  end
endmodule

// [bench/scl_chk.sv]
// Checker for the programming link and the device output gating.
// Assumes it sits beside the one interface that joins host and device.
`timescale 1ns/1ps
module scl_chk #(
  parameter int SETTLE_CYCLES = scl_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic power_down_tristate_n,
  input wire logic locked,
  input wire logic programmed,
  input wire logic [scl_pkg::NUM_OUTPUTS-1:0] clock_out_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic sclk_reg;
  int bits_reg;
  int low_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b0;
      bits_reg <= 0;
      low_reg <= 0;
    end else begin
      sclk_reg <= shift_clock;
      low_reg <= locked ? 0 : low_reg + 1;
      // Count restarts at each strobe so every frame is judged alone
      if (load_strobe) begin
        bits_reg <= 0;
      end else if (shift_clock && !sclk_reg) begin
        bits_reg <= bits_reg + 1;
      end
    end
  end
  sequence s_load;
    $rose(load_strobe);
  endsequence
  sequence s_sclk_high;
    shift_clock[*4] ##1 !shift_clock;
  endsequence
  a_strobe_quiet_shift: assert property ($rose(shift_clock) |-> !load_strobe)
    else $error("strobe high during shift");
  a_bit_hold_high: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_data))
    else $error("data moved while shift clock high");
  a_sclk_high_width: assert property ($rose(shift_clock) |-> s_sclk_high)
    else $error("shift clock high width wrong");
  a_word_bit_count: assert property (s_load |-> bits_reg == scl_pkg::WORD_BITS)
    else $error("frame bit count wrong");
  a_load_marks_programmed: assert property (s_load |-> ##[1:6] programmed)
    else $error("load did not mark programmed");
  a_load_drops_lock: assert property (s_load |-> ##[1:6] !locked)
    else $error("load did not drop lock");
  a_relock_time: assert property ($rose(locked) |-> low_reg == SETTLE_CYCLES)
    else $error("relock time wrong");
  a_pd_tristates: assert property ($fell(power_down_tristate_n) |-> ##[1:4] (&clock_out_oe_n))
    else $error("outputs not released in power down");
  a_pd_drives: assert property ($rose(power_down_tristate_n) |-> ##[1:4] (clock_out_oe_n == '0))
    else $error("outputs not driven after power up");
endmodule

// [bench/serial_config_shift_latch_test.sv]
// Testbench joining host and device ends across one link interface.
// Assumes the package and both ends are compiled first.
`timescale 1ns/1ps
module serial_config_shift_latch_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic hold_off = 1'b0;
  logic ref_in = 1'b0;
  logic [8:0] synth = '0;
  logic [159:0] word = '0;
  logic [159:0] dev_word;
  logic busy, done, programmed, locked, in_range, pd;
  logic [8:0] clk_out, oe_n;
  logic [31:0] seed = 32'h0000_0812;
  logic [31:0] r;
  logic [4:0] odivs [3] = '{5'h02, 5'h14, 5'h15};
  int fail_count = 0;
  int comparisons = 0;
  logic [159:0] notes [$];
  scl_link_if link();
  scl_host i_scl_host (.clk(clk), .rst(rst), .start(start), .cfg_word(word),
    .hold_outputs_off(hold_off), .busy(busy), .done(done), .link(link));
  scl_device #(.SETTLE_CYCLES(20)) i_scl_device (.clk(clk), .rst(rst),
    .reference_clock_in(ref_in), .synth_clocks(synth), .link(link), .cfg_word(dev_word),
    .programmed(programmed), .locked(locked), .cfg_in_range(in_range), .powered_down(pd),
    .clock_out(clk_out), .clock_out_oe_n(oe_n));
  scl_chk #(.SETTLE_CYCLES(20)) i_scl_chk (.clk(clk), .rst(rst),
    .shift_clock(link.shift_clock), .serial_data(link.serial_data),
    .load_strobe(link.load_strobe), .power_down_tristate_n(link.power_down_tristate_n),
    .locked(locked), .programmed(programmed), .clock_out_oe_n(oe_n));
  always #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  always @(negedge clk) begin
    r = rnd();
    ref_in <= r[9];
    synth <= r[8:0];
  end
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic load(input logic [4:0] odiv);
    @(negedge clk);
    word = {rnd(), rnd(), rnd(), rnd(), rnd()};
    word[25:21] = odiv;
    notes.push_back(word);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    // Second start mid-frame must be ignored
    repeat (300) @(negedge clk);
    check(busy, 1'b1);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (2000) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    check(done, 1'b1);
    check(busy, 1'b0);
    repeat (40) @(negedge clk);
    check(locked, 1'b1);
  endtask
  always @(negedge link.load_strobe) begin
    if (!rst && notes.size() > 0) begin
      repeat (4) @(negedge clk);
      check(dev_word, notes[0]);
      check(in_range, notes[0][25:21] >= 2 && notes[0][25:21] <= 20);
      check(programmed, 1'b1);
      check(locked, 1'b0);
      check(clk_out, synth);
      void'(notes.pop_front());
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    #5;
    check(clk_out, {9{ref_in}});
    check(oe_n, 9'h000);
    check(programmed, 1'b0);
    $display("test reset done");
    @(negedge clk);
    hold_off = 1'b1;
    load(5'h01);
    check(oe_n, 9'h1ff);
    check(pd, 1'b1);
    hold_off = 1'b0;
    repeat (4) @(negedge clk);
    check(oe_n, 9'h000);
    check(pd, 1'b0);
    $display("test power down load done");
    foreach (odivs[i]) load(odivs[i]);
    $display("test reload while running done");
    // Every noted load must have been latched and checked
    check(notes.size(), 0);
    close_out();
  end
  initial begin
    repeat (12000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
